// ==== src/pca_pkg.sv ====
// package with addresses, reset values and types of the counter array byte registers
package cab_pkg;
  // special function addresses of the counter bytes
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'hf9;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
  // counter control register, holds the overflow flag
  localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'hd8;
  // bit position of the overflow flag inside the control register
  localparam int CTRL_OVERFLOW_BIT = 7;
  // number of capture/compare modules
  localparam int NUM_MODULES = 5;
  // low and high byte addresses per module, module zero in the lowest slot
  localparam logic [39:0] ADDR_MODULE_LOW = {8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
  localparam logic [39:0] ADDR_MODULE_HIGH = {8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};
  // reset values
  localparam logic [7:0] RESET_COUNTER_HIGH = 8'h00;
  localparam logic [7:0] RESET_COUNTER_LOW = 8'h00;
  localparam logic [7:0] RESET_MODULE_VALUE = 8'h00;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_READ_DATA = 8'h00;
  // value returned by a read of an address that names no register here
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // counter value that wraps on the next count
  localparam logic [15:0] COUNTER_TOP = 16'hffff;
  // simple state of the register access port
  typedef enum logic [1:0] {
    CAB_IDLE = 2'b01,
    CAB_BUSY = 2'b10
  } cab_state_t;
endpackage

// ==== src/pca_regs.sv ====
// byte-wide register view of the programmable counter array
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// overview
// the block holds one 16-bit counter and five 16-bit capture/compare values
// the core reaches every byte through one special function address
// reads answer at the read edge and the data stands until the next read
// writes land at the write edge and show in the next cycle
// a low byte read of the counter catches the high byte for the next high read
// so software sees both halves of one counter value even while it counts
// a high read with no catch pending returns the live high byte
// the control register holds the overflow flag in its top bit
// software may write the control register freely
// a wrap in the same cycle as a control write still leaves the flag set
// counter byte writes win over the count tick of the same cycle
// unmapped reads return zero and unmapped writes do nothing
////////////////////////////////////////////////////////////////////////////////
module cab_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_count_tick,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  output logic o_overflow_flag,
  output logic [15:0] o_counter,
  output logic [79:0] o_module_values
);
  ////////////////////////////////////////////////////////////////////////////////
  // address decode results
  logic hit_low; // address selects the counter low byte
  logic hit_high; // address selects the counter high byte
  logic hit_ctrl; // address selects the control register
  logic [cab_pkg::NUM_MODULES-1:0] hit_mod_low; // address selects a module low byte
  logic [cab_pkg::NUM_MODULES-1:0] hit_mod_high; // address selects a module high byte
  logic addr_mapped; // address names any register of this block
  logic wr_low; // write strobe on the counter low byte
  logic wr_high; // write strobe on the counter high byte
  logic wr_ctrl; // write strobe on the control register

  ////////////////////////////////////////////////////////////////////////////////
  // counter, latch, control and read data state
  logic [15:0] counter; // running counter value
  logic [15:0] next_counter; // next counter value
  logic [7:0] high_latch; // high byte caught on a low byte read
  logic [7:0] next_high_latch; // next latched high byte
  logic latch_valid; // latched high byte waits to be read
  logic next_latch_valid; // next latch state
  logic [7:0] control; // control register, flag at top bit
  logic [7:0] next_control; // next control value
  logic [7:0] rd_data; // registered read data
  logic [7:0] next_rd_data; // next read data
  logic [79:0] modules; // five capture/compare values
  logic [79:0] next_modules; // next capture/compare values
  logic wraps; // counter wraps in this cycle

  ////////////////////////////////////////////////////////////////////////////////
  // fixed register decode, one address at a time
  always_comb begin
    hit_low = 1'b0;
    hit_high = 1'b0;
    hit_ctrl = 1'b0;
    if (i_addr == cab_pkg::ADDR_COUNTER_LOW) begin
      hit_low = 1'b1;
    end else if (i_addr == cab_pkg::ADDR_COUNTER_HIGH) begin
      hit_high = 1'b1;
    end else if (i_addr == cab_pkg::ADDR_COUNTER_CONTROL) begin
      hit_ctrl = 1'b1;
    end
  end

  // write strobes of the fixed registers
  assign wr_low = i_wr_en && hit_low;
  assign wr_high = i_wr_en && hit_high;
  assign wr_ctrl = i_wr_en && hit_ctrl;
  // any register of the block, used to check unmapped reads
  assign addr_mapped = hit_low || hit_high || hit_ctrl || (|hit_mod_low) || (|hit_mod_high);

  ////////////////////////////////////////////////////////////////////////////////
  // next values of counter, latch, control and read data
  always_comb begin
    next_counter = counter;
    next_high_latch = high_latch;
    next_latch_valid = latch_valid;
    next_control = control;
    next_rd_data = rd_data;
    // the counter wraps when a tick meets the top value
    wraps = i_count_tick && (counter == cab_pkg::COUNTER_TOP);
    // counting runs first, software writes override the count
    if (i_count_tick) begin
      next_counter = counter + 16'h0001;
    end
    // counter byte writes and the control write, one address at a time
    if (wr_low) begin
      next_counter[7:0] = i_wr_data;
    end else if (wr_high) begin
      next_counter[15:8] = i_wr_data;
    end else if (wr_ctrl) begin
      next_control = i_wr_data; // software may clear the flag here
    end
    // an overflow in the same cycle as a control write still sets the flag
    if (wraps) begin
      next_control[cab_pkg::CTRL_OVERFLOW_BIT] = 1'b1;
    end
    // read path, data stands from the edge after the read until the next read
    if (i_rd_en) begin
      if (hit_low) begin
        next_rd_data = counter[7:0];
        next_high_latch = counter[15:8];
        next_latch_valid = 1'b1; // armed for the paired high read
      end else if (hit_high) begin
        // latched value pairs with the low byte read before
        next_rd_data = latch_valid ? high_latch : counter[15:8];
        next_latch_valid = 1'b0; // the catch is used up
      end else if (hit_ctrl) begin
        next_rd_data = control;
      end else begin
        // unmapped addresses read as zero
        next_rd_data = cab_pkg::UNMAPPED_READ;
        for (int m = 0; m < cab_pkg::NUM_MODULES; m++) begin
          if (hit_mod_low[m]) begin
            next_rd_data = modules[m*16 +: 8];
          end else if (hit_mod_high[m]) begin
            next_rd_data = modules[m*16+8 +: 8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers of counter, latch, control and read data
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      counter <= {cab_pkg::RESET_COUNTER_HIGH, cab_pkg::RESET_COUNTER_LOW};
      high_latch <= cab_pkg::RESET_COUNTER_HIGH;
      latch_valid <= 1'b0;
      control <= cab_pkg::RESET_CONTROL;
      rd_data <= cab_pkg::RESET_READ_DATA;
    end else begin
      counter <= next_counter;
      high_latch <= next_high_latch;
      latch_valid <= next_latch_valid;
      control <= next_control;
      rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture/compare value bytes, one slice per module
  genvar g;
  generate
    for (g = 0; g < cab_pkg::NUM_MODULES; g++) begin : g_module
      // decode of this module's two byte addresses
      assign hit_mod_low[g] = (i_addr == cab_pkg::ADDR_MODULE_LOW[g*8 +: 8]);
      assign hit_mod_high[g] = (i_addr == cab_pkg::ADDR_MODULE_HIGH[g*8 +: 8]);
      // next value of this module's two bytes
      always_comb begin
        next_modules[g*16 +: 16] = modules[g*16 +: 16];
        if (i_wr_en && hit_mod_low[g]) begin
          next_modules[g*16 +: 8] = i_wr_data;
        end else if (i_wr_en && hit_mod_high[g]) begin
          next_modules[g*16+8 +: 8] = i_wr_data;
        end
      end
      // register this module's bytes
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
          modules[g*16 +: 16] <= {cab_pkg::RESET_MODULE_VALUE, cab_pkg::RESET_MODULE_VALUE};
        end else begin
          modules[g*16 +: 16] <= next_modules[g*16 +: 16];
        end
      end

      // a written low byte lands in this module's value
      a_module_low_store: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_wr_en && hit_mod_low[g]) |=> (modules[g*16 +: 8] == $past(i_wr_data)))
        else $error("module low byte write lost");

      // a written high byte lands in this module's value
      a_module_high_store: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_wr_en && hit_mod_high[g]) |=> (modules[g*16+8 +: 8] == $past(i_wr_data)))
        else $error("module high byte write lost");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign o_rd_data = rd_data;
  assign o_overflow_flag = control[cab_pkg::CTRL_OVERFLOW_BIT];
  assign o_counter = counter;
  assign o_module_values = modules;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions on the counter bytes, the catch and the overflow flag

  // a wrap always leaves the flag set
  a_overflow_sets_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wraps |=> o_overflow_flag)
    else $error("overflow did not set the flag");

  // a wrap during a control write still leaves the flag set
  a_flag_ctrl_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (wraps && wr_ctrl) |=> o_overflow_flag)
    else $error("overflow lost during a control write");

  // a low byte read returns the counter low byte
  a_low_read_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && hit_low) |=> (o_rd_data == $past(counter[7:0])))
    else $error("low byte read wrong");

  // a low byte write lands
  a_low_write_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_low |=> (counter[7:0] == $past(i_wr_data)))
    else $error("low byte write lost");

  // a high byte write lands
  a_high_write_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_high |=> (counter[15:8] == $past(i_wr_data)))
    else $error("high byte write lost");

  // a low byte read arms the catch with the high byte of that moment
  a_latch_loaded: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && hit_low) |=> (latch_valid && (high_latch == $past(counter[15:8]))))
    else $error("high byte not caught on low read");

  // a high read right after a low read returns the caught byte
  a_latch_pairs_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && hit_low) ##1 (i_rd_en && hit_high)
    |=> (o_rd_data == $past(counter[15:8], 2)))
    else $error("high byte not paired with low read");

  // a high read with no catch pending returns the live byte
  a_high_read_live: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && hit_high && !latch_valid) |=> (o_rd_data == $past(counter[15:8])))
    else $error("live high byte read wrong");

  // a high read always uses up the catch
  a_latch_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && hit_high) |=> !latch_valid)
    else $error("catch not cleared by high read");

  // module zero low byte, written then read back at once
  a_module0_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_wr_en && hit_mod_low[0]) ##1 (i_rd_en && hit_mod_low[0] && !i_wr_en)
    |=> (o_rd_data == $past(i_wr_data, 2)))
    else $error("module zero low byte not stored");

  // module four high byte, written then read back at once
  a_module4_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_wr_en && hit_mod_high[4]) ##1 (i_rd_en && hit_mod_high[4] && !i_wr_en)
    |=> (o_rd_data == $past(i_wr_data, 2)))
    else $error("module four high byte not stored");

  // the flag holds unless software writes the control register
  a_flag_held: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (o_overflow_flag && !wr_ctrl) |=> o_overflow_flag)
    else $error("overflow flag dropped without a write");

  // the counter steps by one when no byte write intervenes
  a_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_count_tick && !wr_low && !wr_high) |=> (counter == $past(counter) + 16'h0001))
    else $error("counter did not step by one");

  // read data stands while no read is made
  a_rd_data_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_rd_en |=> $stable(o_rd_data))
    else $error("read data moved without a read");

  // an unmapped read returns zero
  a_unmapped_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && !addr_mapped) |=> (o_rd_data == cab_pkg::UNMAPPED_READ))
    else $error("unmapped read not zero");

  // cover: a wrap meets a control write
  c_wrap_on_ctrl_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wraps && wr_ctrl);
  // cover: low read followed at once by a high read
  c_paired_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_rd_en && hit_low) ##1 (i_rd_en && hit_high));
  // cover: a write to module one low byte
  c_module_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_wr_en && hit_mod_low[1]);
  // cover: a read of an unmapped address
  c_unmapped_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rd_en && !addr_mapped);
endmodule // cab_regs

// ==== tb/tb_counter_array_byte_registers.sv ====
// self-checking testbench of the counter array byte registers
`timescale 1ns/1ns
module tb_counter_array_byte_registers;
  logic i_clk_sys = 1'b0; // 25 MHz system clock
  logic i_rst_b = 1'b0; // async reset, active low
  logic i_count_tick = 1'b0; // counter increment enable
  logic [7:0] i_addr = 8'h00; // register address
  logic i_wr_en = 1'b0; // write strobe
  logic [7:0] i_wr_data = 8'h00; // write data
  logic i_rd_en = 1'b0; // read strobe
  logic [7:0] o_rd_data; // read data, one cycle after the read
  logic o_overflow_flag; // counter overflow flag
  logic [15:0] o_counter; // live counter
  logic [79:0] o_module_values; // five module values
  int fail_count = 0; // mismatches seen
  int checked = 0; // comparisons made
  logic [15:0] exp_mod [5]; // expected module values
  logic [7:0] rv; // byte returned by a read
  logic [7:0] d; // random data byte
  int m; // module index
  int h; // high byte select
  logic [7:0] hb; // high byte seen before the wrap
  cab_regs cab_regs_i (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_count_tick(i_count_tick),
    .i_addr(i_addr),
    .i_wr_en(i_wr_en),
    .i_wr_data(i_wr_data),
    .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data),
    .o_overflow_flag(o_overflow_flag),
    .o_counter(o_counter),
    .o_module_values(o_module_values)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // address of one module byte, from the package tables
  function automatic logic [7:0] mod_addr(input int mi, input int hi);
    return hi ? cab_pkg::ADDR_MODULE_HIGH[8*mi +: 8] : cab_pkg::ADDR_MODULE_LOW[8*mi +: 8];
  endfunction
  // compare one value and count it
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one write cycle, driven at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    @(negedge i_clk_sys);
    i_addr = a;
    i_wr_en = 1'b1;
    i_wr_data = wd;
    @(negedge i_clk_sys);
    i_wr_en = 1'b0;
  endtask
  // one read cycle; data taken at the falling edge just after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] rd_val);
    @(negedge i_clk_sys);
    i_addr = a;
    i_rd_en = 1'b1;
    @(negedge i_clk_sys);
    i_rd_en = 1'b0;
    rd_val = o_rd_data;
  endtask
  // hold the tick high for n rising edges
  task automatic tick(input int n);
    @(negedge i_clk_sys);
    i_count_tick = 1'b1;
    repeat (n) @(negedge i_clk_sys);
    i_count_tick = 1'b0;
  endtask
  // verdict and end of run
  task automatic end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(82704));
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_rst_b = 1'b1;
    // reset values of counter and modules
    rd(cab_pkg::ADDR_COUNTER_HIGH, rv);
    chk("high reset", rv, 8'h00);
    for (m = 0; m < 5; m++) begin
      exp_mod[m] = 16'h0000;
      rd(mod_addr(m, 0), rv);
      chk("mod low reset", rv, 8'h00);
      rd(mod_addr(m, 1), rv);
      chk("mod high reset", rv, 8'h00);
    end
    rd(8'h80, rv);
    chk("unmapped", rv, 8'h00);
    $display("test reset done");
    // random module byte writes with read-back
    for (int k = 0; k < 30; k++) begin
      m = $urandom % 5;
      h = $urandom % 2;
      d = 8'($urandom);
      wr(mod_addr(m, h), d);
      if (h) begin
        exp_mod[m][15:8] = d;
      end else begin
        exp_mod[m][7:0] = d;
      end
      rd(mod_addr(m, h), rv);
      chk("mod readback", rv, d);
      chk("mod value", o_module_values[16*m +: 16], exp_mod[m]);
    end
    // write then read in the very next cycle, module zero low and module four high
    for (h = 0; h < 2; h++) begin
      m = h ? 4 : 0;
      d = 8'($urandom);
      @(negedge i_clk_sys);
      i_addr = mod_addr(m, h);
      i_wr_en = 1'b1;
      i_wr_data = d;
      @(negedge i_clk_sys);
      i_wr_en = 1'b0;
      i_rd_en = 1'b1;
      @(negedge i_clk_sys);
      i_rd_en = 1'b0;
      chk("mod back to back", o_rd_data, d);
    end
    $display("test module bytes done");
    // counter write, low read latches high across a carry
    wr(cab_pkg::ADDR_COUNTER_HIGH, 8'h12);
    wr(cab_pkg::ADDR_COUNTER_LOW, 8'hff);
    rd(cab_pkg::ADDR_COUNTER_LOW, rv);
    chk("counter low", rv, 8'hff);
    tick(3);
    chk("counter", o_counter, 16'h1302);
    rd(cab_pkg::ADDR_COUNTER_HIGH, rv);
    chk("latched high", rv, 8'h12);
    rd(cab_pkg::ADDR_COUNTER_HIGH, rv);
    chk("live high", rv, 8'h13);
    // low and high read back to back while the counter carries
    wr(cab_pkg::ADDR_COUNTER_LOW, 8'hff);
    @(negedge i_clk_sys);
    i_addr = cab_pkg::ADDR_COUNTER_LOW;
    i_rd_en = 1'b1;
    i_count_tick = 1'b1;
    @(negedge i_clk_sys);
    chk("paired low", o_rd_data, 8'hff);
    i_addr = cab_pkg::ADDR_COUNTER_HIGH;
    @(negedge i_clk_sys);
    i_rd_en = 1'b0;
    i_count_tick = 1'b0;
    chk("paired high", o_rd_data, 8'h13);
    chk("counter after pair", o_counter, 16'h1401);
    $display("test latch done");
    // wrap during a control register write still sets the flag
    wr(cab_pkg::ADDR_COUNTER_CONTROL, 8'h00);
    chk("flag clear", 16'(o_overflow_flag), 16'h0000);
    wr(cab_pkg::ADDR_COUNTER_HIGH, 8'hff);
    wr(cab_pkg::ADDR_COUNTER_LOW, 8'hff);
    // software guard: sample the counter before the control write
    rd(cab_pkg::ADDR_COUNTER_LOW, rv);
    rd(cab_pkg::ADDR_COUNTER_HIGH, hb);
    chk("guard high before", hb, 8'hff);
    @(negedge i_clk_sys);
    i_count_tick = 1'b1;
    i_addr = cab_pkg::ADDR_COUNTER_CONTROL;
    i_wr_en = 1'b1;
    i_wr_data = 8'h00;
    @(negedge i_clk_sys);
    i_count_tick = 1'b0;
    i_wr_en = 1'b0;
    chk("flag set", 16'(o_overflow_flag), 16'h0001);
    chk("wrapped", o_counter, 16'h0000);
    // software guard: sample again and set the flag by hand on a ff to 00 step
    rd(cab_pkg::ADDR_COUNTER_LOW, rv);
    rd(cab_pkg::ADDR_COUNTER_HIGH, rv);
    chk("guard high after", rv, 8'h00);
    if (hb == 8'hff && rv == 8'h00) begin
      wr(cab_pkg::ADDR_COUNTER_CONTROL, 8'h80);
    end
    chk("flag after guard", 16'(o_overflow_flag), 16'h0001);
    $display("test overflow done");
    end_sim();
  end
endmodule // tb_counter_array_byte_registers
